// *** tcvr_regulator.sv ***
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Window limits are offsets from target
// - Slow timer starts once outside window
// - Full slow time elapsed gives one command
// - Return inside window clears the timer
// - Pick-up drops out 3 % inside limit
// - Fast window definite or inverse time
// - Inverse time is delay over deviation percent
// - Inverse mode: fast region inverse, between limits definite
// - Instant lower, only pulse spacing delays
// - Below instant level, window timing resumes
// - Undervoltage blocks all tap operations
// - Overcurrent, internal or external, blocks taps
// - Four voltage channels, 5 ms refresh
// - Three phase currents, 5 ms refresh
// - Five operating modes, behaviour reported
// - Remaining time reported in 5 ms steps
module tcvr_regulator
   import tcvr_pkg::*;
#(
   parameter int TICK_DIV = TICK_CYC
) (
   // Clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rst,
   // Voltage measurements, 0.01 % of nominal
   input  wire logic [VW-1:0]    volt_mag [NVCH],
   input  wire logic [1:0]       volt_sel,
   input  wire logic             volt_valid,
   // Phase current measurements
   input  wire logic [CW-1:0]    phase_a_current_mag,
   input  wire logic [CW-1:0]    phase_b_current_mag,
   input  wire logic [CW-1:0]    phase_c_current_mag,
   input  wire logic             curr_valid,
   // External protection pick-up pin
   input  wire logic             ext_oc_pickup,
   // Settings
   input  wire logic [VW-1:0]    target_voltage,
   input  wire logic [VW-1:0]    slow_over_ofs,
   input  wire logic [VW-1:0]    slow_under_ofs,
   input  wire logic [VW-1:0]    fast_over_ofs,
   input  wire logic [VW-1:0]    fast_under_ofs,
   input  wire logic [VW-1:0]    instant_lower_ofs,
   input  wire logic [VW-1:0]    undervolt_block_level,
   input  wire logic [CW-1:0]    overcurrent_level,
   input  wire logic             oc_block_enable,
   input  wire logic [TMR_W-1:0] slow_delay_ticks,
   input  wire logic [TMR_W-1:0] fast_delay_ticks,
   input  wire logic             fast_inverse_mode,
   input  wire logic [TMR_W-1:0] pulse_ticks,
   input  wire logic [TMR_W-1:0] min_gap_ticks,
   input  wire logic [2:0]       regulator_operating_mode,
   // Tap changer commands
   output logic                  raise_cmd,
   output logic                  lower_cmd,
   // Status
   output logic [2:0]            behaviour_mode,
   output logic [TMR_W-1:0]      timer_left,
   output logic [2:0]            timer_active,
   output logic                  slow_pickup,
   output logic                  fast_pickup,
   output logic                  instant_active,
   output logic                  uv_block,
   output logic                  oc_block
);

   ////////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic [VW-1:0]    volt;
      logic             volt_new;
      logic [NPH-1:0]   curr_over;
      logic             ext_s1;
      logic             ext_s2;
      logic [2:0]       mode;
      tcvr_state_t      st;
      logic [TMR_W-1:0] cnt;
      logic [TMR_W-1:0] gap;
      logic             dir_lower;
      logic             raise;
      logic             lower;
      logic             slow_up;
      logic             slow_dn;
      logic [TMR_W-1:0] fast_req;
      logic [TMR_W-1:0] left;
      logic [2:0]       act;
   } tcvr_reg_st_t;

   tcvr_reg_st_t s_reg;
   tcvr_reg_st_t s_next;

   logic             tick;
   logic             div_done;
   logic [31:0]      div_quo;
   logic [31:0]      div_num;
   logic [15:0]      div_den;
   logic [CW-1:0]    curr [NPH];
   logic [NPH-1:0]   curr_hi;

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers

   tcvr_tick_gen #(
      .DIV (TICK_DIV)
   ) u_tick (
      .ref_clk (ref_clk),
      .rst     (rst),
      .tick    (tick)
   );

   // Drop-out level of a pick-up limit
   function automatic logic [VW-1:0] drop_lvl(input logic [VW-1:0] ofs);
      logic [VW+1:0] h;
      h = ({2'b00, ofs} * HYST_PCT) / PCT_DIV;
      return ofs - h[VW-1:0];
   endfunction

   // Per-phase overcurrent compare
   assign curr[0] = phase_a_current_mag;
   assign curr[1] = phase_b_current_mag;
   assign curr[2] = phase_c_current_mag;
   for (genvar i = 0; i < NPH; i++) begin : g_oc
      assign curr_hi[i] = curr[i] > overcurrent_level;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Deviation from target and region decode

   logic signed [VW+1:0] dev;
   logic [VW+1:0]        negd;
   logic [VW:0]          mag;
   logic                 over;
   logic                 under;
   logic                 fast_up;
   logic                 fast_dn;
   logic                 instant;
   logic                 uv;
   logic                 oc;
   logic                 halt;
   logic                 cmd_ok;

   // Limits follow the target because they are offsets from it
   assign dev     = $signed({2'b00, s_reg.volt}) - $signed({2'b00, target_voltage});
   assign negd    = -dev;
   assign mag     = dev[VW+1] ? negd[VW:0] : dev[VW:0];
   assign over    = !dev[VW+1] && (dev != '0);
   assign under   = dev[VW+1];
   assign fast_up = over && (mag > {1'b0, fast_over_ofs});
   assign fast_dn = under && (mag > {1'b0, fast_under_ofs});
   assign instant = over && (mag > {1'b0, instant_lower_ofs});
   assign uv      = s_reg.volt < undervolt_block_level;
   assign oc      = (oc_block_enable && (|s_reg.curr_over)) || s_reg.ext_s2;
   assign halt    = uv || oc || (s_reg.mode == MODE_OFF);
   assign cmd_ok  = (s_reg.mode == MODE_ON) || (s_reg.mode == MODE_TEST);

   // Inverse time request: delay * 100 / deviation in 0.01 %
   assign div_num = {13'h0000, fast_delay_ticks} * PCT_SCALE;
   assign div_den = mag[VW] ? 16'hffff : mag[VW-1:0];

   tcvr_inv_div u_div (
      .ref_clk (ref_clk),
      .rst     (rst),
      .start   (s_reg.volt_new && (fast_up || fast_dn)),
      .num     (div_num),
      .den     (div_den),
      .done    (div_done),
      .quo     (div_quo)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Next state

   logic [TMR_W-1:0] req;
   logic [TMR_W-1:0] cnt_inc;
   logic             pick;

   always_comb begin
      s_next = s_reg;
      // Measurement capture and pin synchroniser
      s_next.volt_new = volt_valid;
      if (volt_valid) begin
         s_next.volt = volt_mag[volt_sel];
      end
      if (curr_valid) begin
         s_next.curr_over = curr_hi;
      end
      s_next.ext_s1 = ext_oc_pickup;
      s_next.ext_s2 = s_reg.ext_s1;
      s_next.mode   = regulator_operating_mode;
      // Pick-ups with drop-out hysteresis
      if (over && (mag > {1'b0, slow_over_ofs})) begin
         s_next.slow_up = 1'b1;
      end else if (!(over && (mag > {1'b0, drop_lvl(slow_over_ofs)}))) begin
         s_next.slow_up = 1'b0;
      end
      if (under && (mag > {1'b0, slow_under_ofs})) begin
         s_next.slow_dn = 1'b1;
      end else if (!(under && (mag > {1'b0, drop_lvl(slow_under_ofs)}))) begin
         s_next.slow_dn = 1'b0;
      end
      // Inverse result clamped to the timer range
      if (div_done) begin
         if ((|div_quo[31:TMR_W]) || (div_quo[TMR_W-1:0] > TMR_MAX_TICKS)) begin
            s_next.fast_req = TMR_MAX_TICKS;
         end else if (div_quo[TMR_W-1:0] == TMR_ZERO) begin
            s_next.fast_req = TMR_ONE;
         end else begin
            s_next.fast_req = div_quo[TMR_W-1:0];
         end
      end
      // Timing characteristic of the present region
      pick = s_reg.slow_up || s_reg.slow_dn;
      if ((fast_up || fast_dn) && fast_inverse_mode) begin
         req = s_reg.fast_req;
      end else if (fast_up || fast_dn) begin
         req = fast_delay_ticks;
      end else begin
         req = slow_delay_ticks;
      end
      cnt_inc = s_reg.cnt + TMR_ONE;
      // Command sequencer
      case (s_reg.st)
         ST_IDLE: begin
            if (halt) begin
               s_next.cnt = TMR_ZERO;
            end else if (instant) begin
               if (tick) begin
                  s_next.cnt       = TMR_ZERO;
                  s_next.dir_lower = 1'b1;
                  if (cmd_ok) begin
                     s_next.st    = ST_PULSE;
                     s_next.lower = 1'b1;
                     s_next.gap   = pulse_ticks;
                  end
               end
            end else if (!pick) begin
               s_next.cnt = TMR_ZERO;
            end else if (tick) begin
               if (cnt_inc >= req) begin
                  s_next.cnt       = TMR_ZERO;
                  s_next.dir_lower = s_reg.slow_up;
                  if (cmd_ok) begin
                     s_next.st    = ST_PULSE;
                     s_next.raise = !s_reg.slow_up;
                     s_next.lower = s_reg.slow_up;
                     s_next.gap   = pulse_ticks;
                  end
               end else begin
                  s_next.cnt = cnt_inc;
               end
            end
         end
         ST_PULSE: begin
            if (tick) begin
               if (s_reg.gap <= TMR_ONE) begin
                  s_next.raise = 1'b0;
                  s_next.lower = 1'b0;
                  s_next.gap   = min_gap_ticks;
                  s_next.st    = ST_GAP;
               end else begin
                  s_next.gap = s_reg.gap - TMR_ONE;
               end
            end
         end
         ST_GAP: begin
            // Spacing between pulses, then region timing resumes
            if (tick) begin
               if (s_reg.gap <= TMR_ONE) begin
                  s_next.st = ST_IDLE;
               end else begin
                  s_next.gap = s_reg.gap - TMR_ONE;
               end
            end
         end
         default: begin
            s_next.st    = ST_IDLE;
            s_next.raise = 1'b0;
            s_next.lower = 1'b0;
         end
      endcase
      // Remaining time report
      if (s_reg.st == ST_IDLE && !halt && instant) begin
         s_next.left = TMR_ZERO;
         s_next.act  = TA_INSTANT;
      end else if (s_reg.st == ST_IDLE && !halt && pick && req > s_reg.cnt) begin
         s_next.left = req - s_reg.cnt;
         if (s_reg.slow_up) begin
            s_next.act = fast_up ? TA_FAST_LOWER : TA_SLOW_LOWER;
         end else begin
            s_next.act = fast_dn ? TA_FAST_RAISE : TA_SLOW_RAISE;
         end
      end else begin
         s_next.left = TMR_ZERO;
         s_next.act  = TA_NONE;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registers

   // Reset clears timers and both commands
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s_reg      <= '0;
         s_reg.st   <= ST_IDLE;
         s_reg.mode <= MODE_ON;
      end else begin
         s_reg <= s_next;
      end
   end

   assign raise_cmd      = s_reg.raise;
   assign lower_cmd      = s_reg.lower;
   assign behaviour_mode = s_reg.mode;
   assign timer_left     = s_reg.left;
   assign timer_active   = s_reg.act;
   assign slow_pickup    = pick;
   assign fast_pickup    = fast_up || fast_dn;
   assign instant_active = instant;
   assign uv_block       = uv;
   assign oc_block       = oc;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   a_cmd_exclusive: assert property (!(raise_cmd && lower_cmd))
      else $error("Raise and lower asserted together");

   a_reset_clears: assert property ($past(rst) |-> (s_reg.cnt == TMR_ZERO) && !raise_cmd && !lower_cmd)
      else $error("Reset did not clear timer or commands");

   a_window_return: assert property ((s_reg.st == ST_IDLE && !pick) |=> (s_reg.cnt == TMR_ZERO))
      else $error("Timer not cleared inside window");

   a_timer_start: assert property ((s_reg.st == ST_IDLE && !halt && !instant && pick && tick
      && cnt_inc < req) |=> (s_reg.cnt == $past(s_reg.cnt) + TMR_ONE))
      else $error("Timer did not advance outside window");

   a_slow_fire: assert property ((s_reg.st == ST_IDLE && !halt && !instant && s_reg.slow_up
      && cmd_ok && tick && cnt_inc >= req) |=> lower_cmd ##1 (s_reg.st == ST_PULSE))
      else $error("Expired timer gave no lower command");

   a_instant_lower: assert property ((s_reg.st == ST_IDLE && !halt && instant && cmd_ok && tick)
      |=> lower_cmd && !raise_cmd)
      else $error("Instant lower not issued");

   a_uv_block: assert property ((s_reg.st == ST_IDLE && uv) |=> !$rose(raise_cmd) && !$rose(lower_cmd))
      else $error("Command issued under undervoltage block");

   a_oc_block: assert property ((s_reg.st == ST_IDLE && oc) |=> (s_reg.st == ST_IDLE)
      && (s_reg.cnt == TMR_ZERO))
      else $error("Command timing under overcurrent block");

   a_raise_dir: assert property ($rose(raise_cmd) |-> $past(s_reg.slow_dn) && !$past(instant))
      else $error("Raise without undervoltage pick-up");

   a_mode_report: assert property ((regulator_operating_mode == MODE_OFF) |=> (behaviour_mode == MODE_OFF)
      ##1 (!$rose(lower_cmd) && !$rose(raise_cmd)))
      else $error("Off mode not reported or not quiet");

endmodule
`default_nettype wire

// *** tcvr_pkg.sv ***
package tcvr_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Widths
   localparam int VW     = 16;   // Magnitudes in 0.01 % of nominal
   localparam int CW     = 16;   // Current magnitudes, same scale as the limit
   localparam int TMR_W  = 19;   // Timer in 5 ms ticks, covers 1800 s
   localparam int NVCH   = 4;    // Voltage channels
   localparam int NPH    = 3;    // Phase currents

   ////////////////////////////////////////////////////////////////////////////////
   // Time base
   localparam int CLK_HZ       = 10_000_000;
   localparam int TICK_MS      = 5;
   localparam int TICK_CYC     = CLK_HZ / 1000 * TICK_MS;
   localparam int TMR_MAX_S    = 1800;
   localparam logic [TMR_W-1:0] TMR_MAX_TICKS = TMR_W'(TMR_MAX_S * 1000 / TICK_MS);
   localparam logic [TMR_W-1:0] TMR_ONE       = 19'h00001;
   localparam logic [TMR_W-1:0] TMR_ZERO      = 19'h00000;

   ////////////////////////////////////////////////////////////////////////////////
   // Scaling
   localparam logic [VW+1:0] HYST_PCT  = 18'h00003;   // Pick-up drop-out margin, percent
   localparam logic [VW+1:0] PCT_DIV   = 18'h00064;   // 100
   localparam logic [31:0]   PCT_SCALE = 32'h00000064; // Units per percent

   ////////////////////////////////////////////////////////////////////////////////
   // Operating modes, also used for the behaviour report
   localparam logic [2:0] MODE_ON       = 3'h0;
   localparam logic [2:0] MODE_BLOCKED  = 3'h1;
   localparam logic [2:0] MODE_TEST     = 3'h2;
   localparam logic [2:0] MODE_TEST_BLK = 3'h3;
   localparam logic [2:0] MODE_OFF      = 3'h4;

   // Which timer is counting
   localparam logic [2:0] TA_NONE       = 3'h0;
   localparam logic [2:0] TA_SLOW_LOWER = 3'h1;
   localparam logic [2:0] TA_FAST_LOWER = 3'h2;
   localparam logic [2:0] TA_INSTANT    = 3'h3;
   localparam logic [2:0] TA_SLOW_RAISE = 3'h4;
   localparam logic [2:0] TA_FAST_RAISE = 3'h5;

   // Command sequencer
   typedef enum logic [2:0] {
      ST_IDLE  = 3'h1,
      ST_PULSE = 3'h2,
      ST_GAP   = 3'h4
   } tcvr_state_t;

endpackage

// *** tcvr_tick_gen.sv ***
`timescale 1ns/1ns
`default_nettype none
module tcvr_tick_gen
   import tcvr_pkg::*;
#(
   parameter int DIV = TICK_CYC
) (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic rst,
   // Tick out
   output logic      tick
);

   localparam int DW = $clog2(DIV);

   typedef struct packed {
      logic [DW-1:0] cnt;
      logic          tick;
   } tcvr_tick_st_t;

   tcvr_tick_st_t s_reg;
   tcvr_tick_st_t s_next;

   // Down counter, one pulse per period
   always_comb begin
      s_next = s_reg;
      s_next.tick = 1'b0;
      if (s_reg.cnt == '0) begin
         s_next.cnt  = DW'(DIV - 1);
         s_next.tick = 1'b1;
      end else begin
         s_next.cnt = s_reg.cnt - 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign tick = s_reg.tick;

endmodule
`default_nettype wire

// *** tcvr_inv_div.sv ***
`timescale 1ns/1ns
`default_nettype none
module tcvr_inv_div
   import tcvr_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // Request
   input  wire logic        start,
   input  wire logic [31:0] num,
   input  wire logic [15:0] den,
   // Result
   output logic             done,
   output logic [31:0]      quo
);

   typedef struct packed {
      logic        busy;
      logic [5:0]  cnt;
      logic [31:0] num;
      logic [15:0] den;
      logic [16:0] rem;
      logic [31:0] quo;
      logic        done;
   } tcvr_div_st_t;

   tcvr_div_st_t s_reg;
   tcvr_div_st_t s_next;

   // Restoring division, one quotient bit per cycle
   always_comb begin
      logic [16:0] rem_s;
      rem_s  = '0;
      s_next = s_reg;
      s_next.done = 1'b0;
      if (!s_reg.busy) begin
         if (start) begin
            s_next.busy = 1'b1;
            s_next.cnt  = 6'h20;
            s_next.num  = num;
            s_next.den  = den;
            s_next.rem  = '0;
         end
      end else begin
         rem_s = {s_reg.rem[15:0], s_reg.num[31]};
         s_next.num = {s_reg.num[30:0], 1'b0};
         if (rem_s >= {1'b0, s_reg.den}) begin
            s_next.rem = rem_s - {1'b0, s_reg.den};
            s_next.quo = {s_reg.quo[30:0], 1'b1};
         end else begin
            s_next.rem = rem_s;
            s_next.quo = {s_reg.quo[30:0], 1'b0};
         end
         s_next.cnt = s_reg.cnt - 1'b1;
         if (s_reg.cnt == 6'h01) begin
            s_next.busy = 1'b0;
            s_next.done = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign done = s_reg.done;
   assign quo  = s_reg.quo;

   // Result arrives exactly 33 cycles after an accepted start
   a_div_latency: assert property (@(posedge ref_clk) disable iff (rst)
      (start && !s_reg.busy) |-> ##33 done)
      else $error("Divider result not ready on time");

endmodule
`default_nettype wire

// *** tcvr_tap_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module tcvr_tap_model
   import tcvr_pkg::*;
#(
   parameter int DIV  = 10,
   parameter int STEP = 167
) (
   // Clock, reset and bench load
   input  wire logic          ref_clk,
   input  wire logic          rst,
   input  wire logic          load,
   input  wire logic [VW-1:0] load_val,
   input  wire logic [1:0]    volt_sel,
   // Tap commands
   input  wire logic          raise_cmd,
   input  wire logic          lower_cmd,
   // Measurements
   output logic [VW-1:0]      volt_mag [NVCH],
   output logic               volt_valid,
   output logic               curr_valid
);
   int            cnt;
   logic [VW-1:0] v;
   logic          r_d;
   logic          l_d;
   ////////////////////////////////////////////////////////////////////////////////
   // Each command edge moves the bus voltage by one tap step
   always_ff @(posedge ref_clk) begin
      r_d <= raise_cmd;
      l_d <= lower_cmd;
      if (load) begin
         v <= load_val;
      end else if (raise_cmd && !r_d) begin
         v <= v + VW'(STEP);
      end else if (lower_cmd && !l_d) begin
         v <= v - VW'(STEP);
      end
      cnt <= (rst || cnt == DIV - 1) ? 0 : cnt + 1;
      volt_valid <= !rst && cnt == DIV - 1;
      curr_valid <= !rst && cnt == DIV - 1;
   end
   // Unselected channels carry the inverse level
   always_comb begin
      for (int i = 0; i < NVCH; i++) begin
         volt_mag[i] = (i == int'(volt_sel)) ? v : ~v;
      end
   end
endmodule
`default_nettype wire

// *** tap_changer_voltage_regulator_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
module tap_changer_voltage_regulator_bench;
   import tcvr_pkg::*;
   localparam int TD = 10;
   logic             ref_clk, rst, load, ext_oc, inv, rc, lc, vv, cv, uvb;
   logic [VW-1:0]    lv, tgt;
   logic [VW-1:0]    vm [NVCH];
   logic [1:0]       sel;
   logic [CW-1:0]    ia;
   logic [2:0]       mode, bmode;
   logic [7:0]       lf = 8'h4c;
   int               bad_count, n_checks;
   // Band 1.2 steps with margin over 5 %, fast = slow + step, instant = max - step
   logic [VW-1:0]    s_ofs = 16'h0064, f_ofs = 16'h010b, i_ofs = 16'h0341;
   logic [VW-1:0]    uvl = 16'h2134, ocl = 16'h0100;
   logic [TMR_W-1:0] sd = 19'h00004, fd = 19'h00028, pt = 19'h00001, gp = 19'h00002;
   logic             oce = 1'b1;
   ////////////////////////////////////////////////////////////////////////////////
   tcvr_regulator #(.TICK_DIV(TD)) dut_u (.ref_clk, .rst, .volt_mag(vm), .volt_sel(sel),
      .volt_valid(vv), .phase_a_current_mag(ia), .phase_b_current_mag(ia),
      .phase_c_current_mag(ia), .curr_valid(cv), .ext_oc_pickup(ext_oc),
      .target_voltage(tgt), .slow_over_ofs(s_ofs), .slow_under_ofs(s_ofs),
      .fast_over_ofs(f_ofs), .fast_under_ofs(f_ofs), .instant_lower_ofs(i_ofs),
      .undervolt_block_level(uvl), .overcurrent_level(ocl), .oc_block_enable(oce),
      .slow_delay_ticks(sd), .fast_delay_ticks(fd), .fast_inverse_mode(inv),
      .pulse_ticks(pt), .min_gap_ticks(gp), .regulator_operating_mode(mode),
      .raise_cmd(rc), .lower_cmd(lc), .behaviour_mode(bmode), .timer_left(),
      .timer_active(), .slow_pickup(), .fast_pickup(), .instant_active(),
      .uv_block(uvb), .oc_block());
   tcvr_tap_model #(.DIV(TD)) tap_u (.ref_clk, .rst, .load, .load_val(lv), .volt_sel(sel),
      .raise_cmd(rc), .lower_cmd(lc), .volt_mag(vm), .volt_valid(vv), .curr_valid(cv));
   ////////////////////////////////////////////////////////////////////////////////
   // Clock
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %0d seen %0d", what, exp, seen);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   function automatic logic [7:0] nxt(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   // One case: reference decision, then run the regulator and compare
   task automatic run(input int t, v1, v2, m, i, e, o);
      int dev, ad, dir, req, cyc;
      lf = nxt(lf);
      dev = v1 - t;
      ad = dev < 0 ? -dev : dev;
      dir = dev > 0 ? 1 : 2;
      req = 0;
      if (dev > 833) req = 1;
      else if (ad > 267) req = i ? 4000 / ad : 40;
      else if (ad > 100) req = 4;
      else dir = 0;
      if (v1 < 8500 || e || o || (m != 0 && m != 2)) dir = 0;
      if (v2 != 0 && (v2 - t < 97 && t - v2 < 97)) dir = 0;
      @(posedge ref_clk);
      rst <= 1'b1;
      mode <= 3'h4;
      tgt <= VW'(t);
      inv <= i[0];
      ext_oc <= e[0];
      ia <= o ? 16'h0200 : {8'h00, lf};
      sel <= lf[1:0];
      load <= 1'b1;
      lv <= VW'(v1);
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      load <= 1'b0;
      chk({30'h0, rc, lc}, 0, "cmd after reset");
      repeat (60) @(posedge ref_clk);
      mode <= m[2:0];
      for (cyc = 0; cyc < (dir != 0 ? req + 3 : 14) * TD; cyc++) begin
         @(posedge ref_clk);
         load <= (cyc == 5 && v2 != 0);
         lv <= VW'(v2);
         if (rc || lc) break;
      end
      chk(rc ? 2 : lc ? 1 : 0, dir, "direction");
      chk(rc && lc, 0, "both cmds");
      if (dir != 0) chk(cyc >= (req - 1) * TD, 1, "delay");
      chk(bmode, m, "behaviour");
      chk(uvb, v1 < 8500, "uv flag");
      $display("case target %0d volt %0d dir %0d done", t, v1, dir);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      rst = 1'b1;
      load = 1'b0;
      lv = '0;
      tgt = 16'h2710;
      inv = 1'b0;
      ext_oc = 1'b0;
      ia = '0;
      sel = '0;
      mode = '0;
      repeat (16) @(posedge ref_clk);
      run(10000, 10110 + lf % 40, 0, 0, 0, 0, 0);
      run(10000, 9890 - lf % 40, 0, 0, 0, 0, 0);
      run(10000, 10150, 10098, 0, 0, 0, 0);
      run(10000, 10150, 10090, 0, 0, 0, 0);
      run(10000, 10400, 0, 0, 0, 0, 0);
      run(10000, 10400, 0, 0, 1, 0, 0);
      run(10000, 9500, 0, 0, 1, 0, 0);
      run(10000, 10900, 0, 0, 0, 0, 0);
      run(10000, 8000, 0, 0, 0, 0, 0);
      run(10000, 10150, 0, 0, 0, 1, 0);
      run(10000, 10150, 0, 0, 0, 0, 1);
      run(10500, 10650, 0, 0, 0, 0, 0);
      run(10500, 10150, 0, 0, 0, 0, 0);
      for (int m = 1; m < 5; m++) run(10000, 10150, 0, m, 0, 0, 0);
      give_verdict();
   end
   // Watchdog
   initial begin
      repeat (20000) @(posedge ref_clk);
      bad_count++;
      give_verdict();
   end
endmodule
`default_nettype wire
